// >>> common/mqtr_pkg.sv
// package: offsets, field layout and constants of the queue transport registers
package mqtr_pkg;
	localparam logic [11:0] OFF_QUEUE_SELECT      = 12'h030;
	localparam logic [11:0] OFF_QUEUE_SIZE_LIMIT  = 12'h034;
	localparam logic [11:0] OFF_QUEUE_SIZE        = 12'h038;
	localparam logic [11:0] OFF_QUEUE_ENABLE      = 12'h044;
	localparam logic [11:0] OFF_QUEUE_KICK        = 12'h050;
	localparam logic [11:0] OFF_IRQ_PENDING       = 12'h060;
	localparam logic [11:0] OFF_IRQ_CLEAR         = 12'h064;
	localparam logic [11:0] OFF_DEVICE_STATE      = 12'h070;
	localparam logic [11:0] OFF_DESC_AREA_ADDR_LO = 12'h080;
	localparam logic [11:0] OFF_DESC_AREA_ADDR_HI = 12'h084;
	localparam logic [11:0] OFF_DRV_AREA_ADDR_LO  = 12'h090;
	localparam logic [11:0] OFF_DRV_AREA_ADDR_HI  = 12'h094;
	localparam logic [11:0] OFF_DEV_AREA_ADDR_LO  = 12'h0a0;
	localparam logic [11:0] OFF_DEV_AREA_ADDR_HI  = 12'h0a4;
	localparam logic [11:0] OFF_SHARED_REGION_SEL = 12'h0ac;
	// kick word layout with notification data
	localparam int KICK_QUEUE_LSB = 0;
	localparam int KICK_QUEUE_W   = 16;
	localparam int KICK_OFF_LSB   = 16;
	localparam int KICK_OFF_W     = 15;
	localparam int KICK_WRAP_BIT  = 31;
	// pending event bits
	localparam int IRQ_USED_BIT   = 0;
	localparam int IRQ_CONFIG_BIT = 1;
	localparam int IRQ_W          = 2;
	// reset word, default queue count and size limit, size width
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam int DEF_QUEUES        = 4;
	localparam int DEF_SIZE_LIMIT    = 256;
	localparam int QSIZE_W           = 16;
endpackage

// >>> design/mqtr_queue_store.sv
// per-queue configuration store: size, enable flag and three area addresses
`timescale 1ns/1ps
module mqtr_queue_store #(
	parameter int QUEUES = mqtr_pkg::DEF_QUEUES,
	parameter int SEL_W  = 2
) (
	// clock, reset, enable
	input  wire logic               clk,
	input  wire logic               rst_sync_n,
	input  wire logic               ce,
	// access
	input  wire logic [SEL_W-1:0]   sel,
	input  wire logic               sel_valid,
	input  wire logic               wr,
	input  wire logic [11:0]        addr,
	input  wire logic [31:0]        wdata,
	input  wire logic               dev_reset,
	// selected queue view
	output logic [15:0]             size_sel,
	output logic                    enable_sel,
	output logic [63:0]             desc_sel,
	output logic [63:0]             drv_sel,
	output logic [63:0]             dev_sel,
	output logic [QUEUES-1:0]       enable_all
);
	typedef struct packed {
		logic [QUEUES-1:0][15:0] size;
		logic [QUEUES-1:0]       enable;
		logic [QUEUES-1:0][63:0] desc;
		logic [QUEUES-1:0][63:0] drv;
		logic [QUEUES-1:0][63:0] dev;
	} mqtr_qstate_t;

	mqtr_qstate_t st;
	mqtr_qstate_t next_st;

	always_comb begin
		next_st = st;
		if (wr && sel_valid) begin
			case (addr)
				mqtr_pkg::OFF_QUEUE_SIZE: begin
					next_st.size[sel] = wdata[15:0]; // R03
				end
				mqtr_pkg::OFF_QUEUE_ENABLE: begin
					next_st.enable[sel] = wdata[0]; // R04
				end
				mqtr_pkg::OFF_DESC_AREA_ADDR_LO: begin
					next_st.desc[sel][31:0] = wdata; // R13
				end
				mqtr_pkg::OFF_DESC_AREA_ADDR_HI: begin
					next_st.desc[sel][63:32] = wdata; // R13
				end
				mqtr_pkg::OFF_DRV_AREA_ADDR_LO: begin
					next_st.drv[sel][31:0] = wdata; // R14
				end
				mqtr_pkg::OFF_DRV_AREA_ADDR_HI: begin
					next_st.drv[sel][63:32] = wdata; // R14
				end
				mqtr_pkg::OFF_DEV_AREA_ADDR_LO: begin
					next_st.dev[sel][31:0] = wdata; // R15
				end
				mqtr_pkg::OFF_DEV_AREA_ADDR_HI: begin
					next_st.dev[sel][63:32] = wdata; // R15
				end
				default: begin
				end
			endcase
		end
		// device reset drops every ready flag, addresses are kept
		if (dev_reset) begin
			next_st.enable = '0; // R18
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// out-of-range selection reads as zero
	assign size_sel   = sel_valid ? st.size[sel] : 16'h0000;
	assign enable_sel = sel_valid ? st.enable[sel] : 1'b0;
	assign desc_sel   = sel_valid ? st.desc[sel] : 64'h0;
	assign drv_sel    = sel_valid ? st.drv[sel] : 64'h0;
	assign dev_sel    = sel_valid ? st.dev[sel] : 64'h0;
	assign enable_all = st.enable;
endmodule

// >>> design/mqtr_regs.sv
// register bank of the memory-mapped queue transport
// Function
// R01 - queue select steers per-queue registers
// R02 - size limit reads max or zero
// R03 - store queue size per queue
// R04 - ready flag written and read back
// R05 - any kick write pulses notify
// R06 - notification data split 16/15/1
// R07 - pending bit 0 used buffer
// R08 - pending bit 1 configuration change
// R09 - clear mask acknowledges pending bits
// R10 - state register reads recorded flags
// R11 - non-zero state write sets flags
// R12 - zero state write resets device
// R13 - descriptor area address stored per queue
// R14 - driver area address stored per queue
// R15 - device area address stored per queue
// R16 - shared region select stored
// R17 - pending bits sticky until acknowledged
// R18 - reset clears pending and ready flags
// R19 - driver uses aligned 32-bit accesses
// R20 - registers little-endian
// R21 - interrupt high while any pending
// R22 - ignore read-only writes, write-only reads zero
`timescale 1ns/1ps
module mqtr_regs #(
	parameter int QUEUES     = mqtr_pkg::DEF_QUEUES,
	parameter int SIZE_LIMIT = mqtr_pkg::DEF_SIZE_LIMIT
) (
	// clock, reset, enable
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	// register port
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [11:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	output logic [31:0]      reg_rdata,
	// device side events and options
	input  wire logic        used_event,
	input  wire logic        config_event,
	input  wire logic        notify_data_en,
	// notification out
	output logic             kick_valid,
	output logic [15:0]      kick_queue,
	output logic [14:0]      kick_next_off,
	output logic             kick_next_wrap,
	// queue and device state out
	output logic [QUEUES-1:0] queue_ready,
	output logic [31:0]      shared_region,
	output logic             dev_reset,
	output logic             irq
);
	localparam int SEL_W = (QUEUES > 1) ? $clog2(QUEUES) : 1;

	typedef struct packed {
		logic [31:0] qsel;
		logic [31:0] state;
		logic [31:0] shm_sel;
		logic [mqtr_pkg::IRQ_W-1:0] pending;
		logic [31:0] rdata;
		logic        kick_v;
		logic [15:0] kick_q;
		logic [14:0] kick_o;
		logic        kick_w;
		logic        dreset;
	} mqtr_state_t;

	mqtr_state_t st;
	mqtr_state_t next_st;
	logic [1:0]  rst_sync;

	logic        rst_sync_n;
	logic        sel_valid;
	logic [15:0] size_sel;
	logic        enable_sel;
	logic [63:0] desc_sel;
	logic [63:0] drv_sel;
	logic [63:0] dev_sel;
	logic        wr_zero_state;

	// reset release through two flops; only the second is used
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_sync_n = rst_sync[1];

	// selection beyond the implemented queues addresses nothing
	assign sel_valid = (st.qsel < 32'(QUEUES)); // R01
	assign wr_zero_state = reg_wr && (reg_addr == mqtr_pkg::OFF_DEVICE_STATE)
		&& (reg_wdata == mqtr_pkg::RST_WORD); // R12

	mqtr_queue_store #(
		.QUEUES (QUEUES),
		.SEL_W  (SEL_W)
	) u_store (
		.clk        (clk),
		.rst_sync_n (rst_sync_n),
		.ce         (ce),
		.sel        (st.qsel[SEL_W-1:0]),
		.sel_valid  (sel_valid),
		.wr         (reg_wr),
		.addr       (reg_addr),
		.wdata      (reg_wdata),
		.dev_reset  (wr_zero_state),
		.size_sel   (size_sel),
		.enable_sel (enable_sel),
		.desc_sel   (desc_sel),
		.drv_sel    (drv_sel),
		.dev_sel    (dev_sel),
		.enable_all (queue_ready)
	);

	// read value; write-only and unmapped words read zero
	function automatic logic [31:0] read_word(input logic [11:0] a,
		input logic v, input logic en, input logic [31:0] stat,
		input logic [mqtr_pkg::IRQ_W-1:0] pend);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (a)
			mqtr_pkg::OFF_QUEUE_SIZE_LIMIT: begin
				r = v ? 32'(SIZE_LIMIT) : 32'h0000_0000; // R02
			end
			mqtr_pkg::OFF_QUEUE_ENABLE: begin
				r = {31'h0, en}; // R04
			end
			mqtr_pkg::OFF_IRQ_PENDING: begin
				r = {30'h0, pend}; // R07 R08
			end
			mqtr_pkg::OFF_DEVICE_STATE: begin
				r = stat; // R10
			end
			default: begin
				r = 32'h0000_0000; // R22
			end
		endcase
		return r;
	endfunction

	always_comb begin
		next_st = st;
		next_st.kick_v = 1'b0;
		next_st.dreset = 1'b0;
		// bit 0 of the bus is bit 0 of the word: little-endian lanes
		if (reg_rd) begin
			next_st.rdata = read_word(reg_addr, sel_valid, enable_sel,
				st.state, st.pending); // R20
		end
		if (reg_wr) begin
			case (reg_addr)
				mqtr_pkg::OFF_QUEUE_SELECT: begin
					next_st.qsel = reg_wdata; // R01
				end
				mqtr_pkg::OFF_QUEUE_KICK: begin
					next_st.kick_v = 1'b1; // R05
					if (notify_data_en) begin
						next_st.kick_q = reg_wdata[mqtr_pkg::KICK_QUEUE_LSB
							+: mqtr_pkg::KICK_QUEUE_W]; // R06
						next_st.kick_o = reg_wdata[mqtr_pkg::KICK_OFF_LSB
							+: mqtr_pkg::KICK_OFF_W]; // R06
						next_st.kick_w = reg_wdata[mqtr_pkg::KICK_WRAP_BIT];
					end else begin
						// plain queue index; upper bits beyond 16 are dropped
						next_st.kick_q = reg_wdata[15:0]; // R05
						next_st.kick_o = 15'h0000;
						next_st.kick_w = 1'b0;
					end
				end
				mqtr_pkg::OFF_DEVICE_STATE: begin
					if (reg_wdata != mqtr_pkg::RST_WORD) begin
						next_st.state = reg_wdata; // R11
					end
				end
				mqtr_pkg::OFF_SHARED_REGION_SEL: begin
					next_st.shm_sel = reg_wdata; // R16
				end
				default: begin
					// read-only and unmapped words take no write
				end // R22
			endcase
		end
		// acknowledge first, new events after: a set wins over a clear
		if (reg_wr && reg_addr == mqtr_pkg::OFF_IRQ_CLEAR) begin
			next_st.pending = st.pending & ~reg_wdata[1:0]; // R09 R17
		end
		if (wr_zero_state) begin
			next_st.state = mqtr_pkg::RST_WORD; // R12
			next_st.pending = '0; // R18
			next_st.qsel = 32'h0;
			next_st.dreset = 1'b1; // R12
		end
		if (used_event) begin
			next_st.pending[mqtr_pkg::IRQ_USED_BIT] = 1'b1; // R07 R17
		end
		if (config_event) begin
			next_st.pending[mqtr_pkg::IRQ_CONFIG_BIT] = 1'b1; // R08 R17
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign reg_rdata      = st.rdata;
	assign kick_valid     = st.kick_v;
	assign kick_queue     = st.kick_q;
	assign kick_next_off  = st.kick_o;
	assign kick_next_wrap = st.kick_w;
	assign shared_region  = st.shm_sel;
	assign dev_reset      = st.dreset;
	assign irq            = |st.pending; // R21

	property p_irq_follows;
		@(posedge clk) disable iff (!rst_sync_n)
		(ce && (used_event || config_event)) |=> irq;
	endproperty
	a_irq_follows: assert property (p_irq_follows) // R21
		else $error("irq does not follow pending bits");

	property p_used_sticky;
		@(posedge clk) disable iff (!rst_sync_n)
		(ce && used_event) |=> st.pending[mqtr_pkg::IRQ_USED_BIT];
	endproperty
	a_used_sticky: assert property (p_used_sticky) // R07
		else $error("used event not recorded");

	property p_config_sticky;
		@(posedge clk) disable iff (!rst_sync_n)
		(ce && config_event) |=> st.pending[mqtr_pkg::IRQ_CONFIG_BIT];
	endproperty
	a_config_sticky: assert property (p_config_sticky) // R08
		else $error("config event not recorded");

	property p_hold_pending;
		@(posedge clk) disable iff (!rst_sync_n)
		(ce && !(reg_wr && (reg_addr == mqtr_pkg::OFF_IRQ_CLEAR
			|| reg_addr == mqtr_pkg::OFF_DEVICE_STATE)))
		|=> (st.pending & $past(st.pending)) == $past(st.pending);
	endproperty
	a_hold_pending: assert property (p_hold_pending) // R17
		else $error("pending bit dropped without acknowledge");

	property p_ack_clears;
		@(posedge clk) disable iff (!rst_sync_n)
		(ce && reg_wr && reg_addr == mqtr_pkg::OFF_IRQ_CLEAR
			&& reg_wdata[0] && !used_event && !wr_zero_state)
		|=> !st.pending[mqtr_pkg::IRQ_USED_BIT];
	endproperty
	a_ack_clears: assert property (p_ack_clears) // R09
		else $error("acknowledge did not clear bit 0");

	property p_zero_reset;
		@(posedge clk) disable iff (!rst_sync_n)
		(ce && wr_zero_state) |=> dev_reset && (st.state == 32'h0)
			##1 (ce -> queue_ready == '0);
	endproperty
	a_zero_reset: assert property (p_zero_reset) // R12
		else $error("zero state write did not reset");

	property p_state_set;
		@(posedge clk) disable iff (!rst_sync_n)
		(ce && reg_wr && reg_addr == mqtr_pkg::OFF_DEVICE_STATE
			&& reg_wdata != 32'h0) |=> st.state == $past(reg_wdata);
	endproperty
	a_state_set: assert property (p_state_set) // R11
		else $error("state write not stored");

	property p_kick_pulse;
		@(posedge clk) disable iff (!rst_sync_n)
		(ce && reg_wr && reg_addr == mqtr_pkg::OFF_QUEUE_KICK)
		|=> kick_valid && kick_queue == $past(reg_wdata[15:0]);
	endproperty
	a_kick_pulse: assert property (p_kick_pulse) // R05
		else $error("kick not signalled");

	property p_limit_read;
		@(posedge clk) disable iff (!rst_sync_n)
		(ce && reg_rd && reg_addr == mqtr_pkg::OFF_QUEUE_SIZE_LIMIT
			&& !sel_valid) |=> reg_rdata == 32'h0;
	endproperty
	a_limit_read: assert property (p_limit_read) // R02
		else $error("unavailable queue limit not zero");

	property p_irq_drop;
		@(posedge clk) disable iff (!rst_sync_n)
		(ce && reg_wr && reg_addr == mqtr_pkg::OFF_IRQ_CLEAR
			&& (st.pending & ~reg_wdata[1:0]) == '0
			&& !used_event && !config_event) |=> !irq;
	endproperty
	a_irq_drop: assert property (p_irq_drop) // R21
		else $error("irq still high after full acknowledge");

	property p_size_store;
		@(posedge clk) disable iff (!rst_sync_n)
		(ce && reg_wr && sel_valid
			&& reg_addr == mqtr_pkg::OFF_QUEUE_SIZE)
		|=> size_sel == $past(reg_wdata[15:0]);
	endproperty
	a_size_store: assert property (p_size_store) // R03
		else $error("queue size not stored");

	property p_enable_store;
		@(posedge clk) disable iff (!rst_sync_n)
		(ce && reg_wr && sel_valid
			&& reg_addr == mqtr_pkg::OFF_QUEUE_ENABLE)
		|=> enable_sel == $past(reg_wdata[0]);
	endproperty
	a_enable_store: assert property (p_enable_store) // R04
		else $error("ready flag not stored");

	property p_desc_store;
		@(posedge clk) disable iff (!rst_sync_n)
		(ce && reg_wr && sel_valid
			&& reg_addr == mqtr_pkg::OFF_DESC_AREA_ADDR_LO)
		|=> desc_sel[31:0] == $past(reg_wdata);
	endproperty
	a_desc_store: assert property (p_desc_store) // R13
		else $error("descriptor area low word not stored");

	property p_drv_store;
		@(posedge clk) disable iff (!rst_sync_n)
		(ce && reg_wr && sel_valid
			&& reg_addr == mqtr_pkg::OFF_DRV_AREA_ADDR_HI)
		|=> drv_sel[63:32] == $past(reg_wdata);
	endproperty
	a_drv_store: assert property (p_drv_store) // R14
		else $error("driver area high word not stored");

	property p_dev_store;
		@(posedge clk) disable iff (!rst_sync_n)
		(ce && reg_wr && sel_valid
			&& reg_addr == mqtr_pkg::OFF_DEV_AREA_ADDR_LO)
		|=> dev_sel[31:0] == $past(reg_wdata);
	endproperty
	a_dev_store: assert property (p_dev_store) // R15
		else $error("device area low word not stored");

	property p_kick_data;
		@(posedge clk) disable iff (!rst_sync_n)
		(ce && reg_wr && notify_data_en
			&& reg_addr == mqtr_pkg::OFF_QUEUE_KICK)
		|=> kick_next_off == $past(reg_wdata[30:16])
			&& kick_next_wrap == $past(reg_wdata[31]);
	endproperty
	a_kick_data: assert property (p_kick_data) // R06
		else $error("notification data fields misdecoded");

	property p_region_store;
		@(posedge clk) disable iff (!rst_sync_n)
		(ce && reg_wr && reg_addr == mqtr_pkg::OFF_SHARED_REGION_SEL)
		|=> shared_region == $past(reg_wdata);
	endproperty
	a_region_store: assert property (p_region_store) // R16
		else $error("shared region select not stored");
endmodule

// >>> testbench/mqtr_drv_model.sv
// driver model: register port master issuing aligned word accesses
`timescale 1ns/1ps
module mqtr_drv_model (
	// clock
	input  wire logic        clk,
	// register port
	output logic             reg_wr,
	output logic             reg_rd,
	output logic [11:0]      reg_addr,
	output logic [31:0]      reg_wdata,
	input  wire logic [31:0] reg_rdata
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 12'hfff;
		reg_wdata = 32'h0;
	end
	// released bus shows the inverse so stale values never look valid
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(negedge clk);
		reg_addr = {a[11:2], 2'b00};
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		@(negedge clk);
		reg_addr = {a[11:2], 2'b00};
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
	endtask
endmodule

// >>> testbench/tb_top.sv
// testbench: register sequences with expected values
`timescale 1ns/1ps
module tb_top;
	logic              clk = 1'b0;
	logic              rst_n;
	logic              ce;
	logic              reg_wr;
	logic              reg_rd;
	logic [11:0]       reg_addr;
	logic [31:0]       reg_wdata;
	logic [31:0]       reg_rdata;
	logic              used_event;
	logic              config_event;
	logic              notify_data_en;
	logic              kick_valid;
	logic [15:0]       kick_queue;
	logic [14:0]       kick_next_off;
	logic              kick_next_wrap;
	logic [3:0]        queue_ready;
	logic [31:0]       shared_region;
	logic              dev_reset;
	logic              irq;
	int                err_count = 0;
	int                checked = 0;
	logic [11:0]       wo [12] = '{12'h030, 12'h038, 12'h050, 12'h064,
		12'h080, 12'h084, 12'h090, 12'h094, 12'h0a0, 12'h0a4, 12'h0ac,
		12'h0fc};

	always #10 clk = ~clk;

	mqtr_drv_model drv (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

	mqtr_regs #(.QUEUES(4), .SIZE_LIMIT(256)) dut (.clk(clk),
		.rst_n(rst_n), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.used_event(used_event), .config_event(config_event),
		.notify_data_en(notify_data_en), .kick_valid(kick_valid),
		.kick_queue(kick_queue), .kick_next_off(kick_next_off),
		.kick_next_wrap(kick_next_wrap), .queue_ready(queue_ready),
		.shared_region(shared_region), .dev_reset(dev_reset), .irq(irq));

	task automatic chk(input string n, input logic [63:0] s,
		input logic [63:0] e);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e,
		input string n);
		logic [31:0] v;
		drv.rd(a, v);
		chk(n, {32'h0, v}, {32'h0, e});
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// hang guard: every access has fixed latency, so this only trips on a stall
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		complete_run();
	end

	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		used_event = 1'b0;
		config_event = 1'b0;
		notify_data_en = 1'b0;
		repeat (8) @(posedge clk);
		@(negedge clk) rst_n = 1'b1;
		repeat (4) @(negedge clk);
		chk("irq", {63'h0, irq}, 64'h0);
		rc(12'h070, 32'h0, "state");
		rc(12'h060, 32'h0, "pending");
		for (int q = 0; q < 4; q++) begin
			drv.wr(12'h030, 32'(q));
			drv.wr(12'h038, 32'(16 + q));
			drv.wr(12'h044, 32'(q & 1));
			drv.wr(12'h080, 32'(q));
			drv.wr(12'h094, 32'hffff_0000);
			drv.wr(12'h0a0, 32'h1234_5678);
		end
		for (int q = 0; q < 4; q++) begin
			drv.wr(12'h030, 32'(q));
			rc(12'h044, 32'(q & 1), "enable");
			rc(12'h034, 32'h0000_0100, "limit");
			chk("size", {48'h0, dut.size_sel}, 64'(16 + q));
			chk("desc", dut.desc_sel, {32'h0, 32'(q)});
			chk("drv", dut.drv_sel, 64'hffff_0000_0000_0000);
			chk("dev", dut.dev_sel, 64'h0000_0000_1234_5678);
		end
		chk("ready", {60'h0, queue_ready}, 64'ha);
		drv.wr(12'h030, 32'h4);
		rc(12'h034, 32'h0, "limit absent");
		rc(12'h044, 32'h0, "enable absent");
		drv.wr(12'h030, 32'h0);
		drv.wr(12'h034, 32'h0000_0007);
		drv.wr(12'h060, 32'h3);
		rc(12'h034, 32'h0000_0100, "limit kept");
		rc(12'h060, 32'h0, "pending kept");
		foreach (wo[i]) begin
			rc(wo[i], 32'h0, "write-only");
		end
		drv.wr(12'h050, 32'hdead_0005);
		chk("kick", {31'h0, kick_valid, kick_next_wrap, kick_next_off,
			kick_queue}, {31'h0, 1'b1, 1'b0, 15'h0, 16'h0005});
		notify_data_en = 1'b1;
		drv.wr(12'h050, 32'h8123_0002);
		chk("kick data", {31'h0, kick_valid, kick_next_wrap, kick_next_off,
			kick_queue}, {31'h0, 1'b1, 1'b1, 15'h0123, 16'h0002});
		@(negedge clk);
		chk("kick pulse", {63'h0, kick_valid}, 64'h0);
		@(negedge clk) used_event = 1'b1;
		@(negedge clk) used_event = 1'b0;
		rc(12'h060, 32'h1, "pending used");
		chk("irq on", {63'h0, irq}, 64'h1);
		@(negedge clk) config_event = 1'b1;
		@(negedge clk) config_event = 1'b0;
		rc(12'h060, 32'h3, "pending both");
		drv.wr(12'h064, 32'h1);
		rc(12'h060, 32'h2, "pending after ack");
		chk("irq held", {63'h0, irq}, 64'h1);
		drv.wr(12'h064, 32'h2);
		rc(12'h060, 32'h0, "pending cleared");
		chk("irq off", {63'h0, irq}, 64'h0);
		drv.wr(12'h070, 32'h0000_000f);
		rc(12'h070, 32'h0000_000f, "state set");
		ce = 1'b0;
		drv.wr(12'h070, 32'h0000_0003);
		ce = 1'b1;
		rc(12'h070, 32'h0000_000f, "state frozen");
		@(negedge clk) used_event = 1'b1;
		@(negedge clk) used_event = 1'b0;
		drv.wr(12'h070, 32'h0);
		chk("dev reset", {63'h0, dev_reset}, 64'h1);
		rc(12'h060, 32'h0, "pending reset");
		chk("dev reset pulse", {63'h0, dev_reset}, 64'h0);
		chk("ready reset", {60'h0, queue_ready}, 64'h0);
		rc(12'h070, 32'h0, "state reset");
		drv.wr(12'h0ac, 32'h0000_0007);
		chk("region", {32'h0, shared_region}, 64'h7);
		complete_run();
	end
endmodule
